// ### rtl/ira_pkg.sv
// Constants for the indirect register store: word indices, widths, reset values and tick timing.
// Assumes one 250 MHz clock and a host that writes the direct data and address ports.
package ira_pkg;

  // ----------------------------------------------------------------
  // Widths and depth
  // ----------------------------------------------------------------
  localparam int IRA_DATA_W = 16;
  localparam int IRA_ADDR_W = 8;
  localparam int IRA_DEPTH = 26;
  localparam int IRA_LOW_TONES = 4;
  localparam int IRA_HIGH_TONES = 4;

  typedef logic [IRA_DATA_W-1:0] ira_word_t;
  typedef logic [IRA_ADDR_W-1:0] ira_addr_t;

  // ----------------------------------------------------------------
  // Indirect word indices
  // ----------------------------------------------------------------
  localparam ira_addr_t IRA_DTMF_FIRST_ROW_PASS_RATIO = 8'h00;
  localparam ira_addr_t IRA_DTMF_SECOND_ROW_PASS_RATIO = 8'h01;
  localparam ira_addr_t IRA_DTMF_THIRD_ROW_PASS_RATIO = 8'h02;
  localparam ira_addr_t IRA_DTMF_FOURTH_ROW_PASS_RATIO = 8'h03;
  localparam ira_addr_t IRA_DTMF_HIGH_GROUP_PASS_RATIO = 8'h04;
  localparam ira_addr_t IRA_DTMF_FORWARD_TWIST_LIMIT = 8'h05;
  localparam ira_addr_t IRA_DTMF_REVERSE_TWIST_LIMIT = 8'h06;
  localparam ira_addr_t IRA_DTMF_LOW_GROUP_DOMINANCE = 8'h07;
  localparam ira_addr_t IRA_DTMF_HIGH_GROUP_DOMINANCE = 8'h08;
  localparam ira_addr_t IRA_DTMF_LOW_GROUP_HARMONIC_LIMIT = 8'h09;
  localparam ira_addr_t IRA_DTMF_HIGH_GROUP_HARMONIC_LIMIT = 8'h0a;
  localparam ira_addr_t IRA_DTMF_MIN_TOTAL_POWER = 8'h0b;
  localparam ira_addr_t IRA_DTMF_AGC_HOT_LIMIT = 8'h0c;
  localparam ira_addr_t IRA_TONE_GEN_ONE_FREQ_COEF = 8'h0d;
  localparam ira_addr_t IRA_TONE_GEN_ONE_AMPLITUDE = 8'h0e;
  localparam ira_addr_t IRA_TONE_GEN_ONE_INITIAL_PHASE = 8'h0f;
  localparam ira_addr_t IRA_TONE_GEN_TWO_FREQ_COEF = 8'h10;
  localparam ira_addr_t IRA_TONE_GEN_TWO_AMPLITUDE = 8'h11;
  localparam ira_addr_t IRA_TONE_GEN_TWO_INITIAL_PHASE = 8'h12;
  localparam ira_addr_t IRA_RINGING_DC_OFFSET = 8'h13;
  localparam ira_addr_t IRA_RINGING_FREQ_COEF = 8'h14;
  localparam ira_addr_t IRA_RINGING_AMPLITUDE = 8'h15;
  localparam ira_addr_t IRA_RINGING_INITIAL_PHASE = 8'h16;
  localparam ira_addr_t IRA_METERING_RAMP_RATE = 8'h17;
  localparam ira_addr_t IRA_METERING_AMPLITUDE = 8'h18;
  localparam ira_addr_t IRA_METERING_FREQ_COEF = 8'h19;

  // ----------------------------------------------------------------
  // Encodings of a unity ratio
  // ----------------------------------------------------------------
  localparam ira_word_t IRA_TONE_UNITY = 16'h7ff0;
  localparam ira_word_t IRA_RATIO_UNITY = 16'h07f0;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam ira_word_t IRA_PORT_RESET = 16'h0000;
  localparam ira_addr_t IRA_ADDR_RESET = 8'h00;
  localparam int IRA_CLK_HZ = 250_000_000;
  localparam int IRA_UPDATE_RATE_HZ = 16_000;
  localparam int IRA_UPDATE_CYCLES = IRA_CLK_HZ / IRA_UPDATE_RATE_HZ;

endpackage

// ### rtl/ira_tick.sv
// Update tick generator: one-cycle pulse every TICK_CYCLES clocks.
// Assumes TICK_CYCLES of at least 2.
`timescale 1ns/1ps
`default_nettype none

module ira_tick
#(
  parameter int TICK_CYCLES = 15625
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Tick
  output logic tick_o
);

  localparam int CNT_W = $clog2(TICK_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TICK_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      cnt_q <= CNT_ZERO;
    end
    else if (cnt_q == CNT_LAST)
    begin
      cnt_q <= CNT_ZERO;
    end
    else
    begin
      cnt_q <= cnt_q + CNT_ONE;
    end
  end

  assign tick_o = (cnt_q == CNT_LAST) && !reset_i;

  chk_tick_gap: assert property (@(posedge mclk_i) disable iff (reset_i)
    tick_o |=> !tick_o)
    else $error("update tick repeated on consecutive cycles");

endmodule

`default_nettype wire

// ### rtl/ira_regs.sv
// Indirect register store behind the direct data and address ports, with threshold checks.
// Assumes host write strobes and detector measures are synchronous to mclk_i.
`timescale 1ns/1ps
`default_nettype none

module ira_regs
  import ira_pkg::*;
#(
  parameter int TICK_CYCLES = ira_pkg::IRA_UPDATE_CYCLES
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Direct data port
  input wire logic data_wr_i,
  input wire ira_pkg::ira_word_t data_wdata_i,
  output ira_pkg::ira_word_t indirect_data_port_o,
  // Direct address port
  input wire logic addr_wr_i,
  input wire ira_pkg::ira_addr_t addr_wdata_i,
  output ira_pkg::ira_addr_t indirect_addr_port_o,
  // Status and interrupt
  output logic indirect_xfer_pending_o,
  input wire logic done_irq_en_i,
  input wire logic done_clr_i,
  output logic transfer_done_irq_o,
  // Detector measures, two's complement ratios
  input wire logic [ira_pkg::IRA_LOW_TONES-1:0][ira_pkg::IRA_DATA_W-1:0] low_tone_ratio_i,
  input wire logic [ira_pkg::IRA_HIGH_TONES-1:0][ira_pkg::IRA_DATA_W-1:0] high_tone_ratio_i,
  input wire ira_pkg::ira_word_t fwd_twist_ratio_i,
  input wire ira_pkg::ira_word_t rev_twist_ratio_i,
  input wire ira_pkg::ira_word_t low_dom_ratio_i,
  input wire ira_pkg::ira_word_t high_dom_ratio_i,
  input wire ira_pkg::ira_word_t low_harm_ratio_i,
  input wire ira_pkg::ira_word_t high_harm_ratio_i,
  input wire ira_pkg::ira_word_t total_power_i,
  input wire ira_pkg::ira_word_t input_level_i,
  // Detector decisions
  output logic [ira_pkg::IRA_LOW_TONES-1:0] low_tone_detect_o,
  output logic [ira_pkg::IRA_HIGH_TONES-1:0] high_tone_detect_o,
  output logic fwd_twist_ok_o,
  output logic rev_twist_ok_o,
  output logic low_dom_ok_o,
  output logic high_dom_ok_o,
  output logic low_harm_ok_o,
  output logic high_harm_ok_o,
  output logic power_valid_o,
  output logic agc_step_down_o,
  // Tone generator coefficients
  output ira_pkg::ira_word_t tone_gen_one_freq_coef_o,
  output ira_pkg::ira_word_t tone_gen_one_amplitude_o,
  output ira_pkg::ira_word_t tone_gen_one_initial_phase_o,
  output ira_pkg::ira_word_t tone_gen_two_freq_coef_o,
  output ira_pkg::ira_word_t tone_gen_two_amplitude_o,
  output ira_pkg::ira_word_t tone_gen_two_initial_phase_o
);

  import ira_pkg::*;

  // ----------------------------------------------------------------
  // Storage and request state
  // ----------------------------------------------------------------
  // No reset on the array; a written mask keeps unwritten words at zero
  ira_word_t mem_q [IRA_DEPTH];
  logic [IRA_DEPTH-1:0] written_q;
  logic data_written_q;
  logic wr_kind_q;
  logic pending_q;
  logic done_q;
  ira_word_t data_q;
  ira_addr_t addr_q;
  logic tick;
  logic service;

  function automatic logic in_range(input ira_addr_t a);
    in_range = (a < IRA_ADDR_W'(IRA_DEPTH));
  endfunction

  function automatic ira_word_t rd_word(input ira_addr_t a);
    rd_word = IRA_PORT_RESET;
    if (in_range(a) && written_q[a[4:0]])
    begin
      rd_word = mem_q[a[4:0]];
    end
  endfunction

  // Signed compare shared by every threshold check
  function automatic logic exceeds(input ira_word_t val, input ira_word_t thr);
    exceeds = ($signed(val) > $signed(thr));
  endfunction

  ira_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .tick_o(tick)
  );

  assign service = tick && pending_q;

  // ----------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      data_written_q <= 1'b0;
    end
    else if (addr_wr_i)
    begin
      data_written_q <= 1'b0;
    end
    else if (data_wr_i)
    begin
      data_written_q <= 1'b1;
    end
  end

  // A new address write replaces any request not yet serviced
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      addr_q <= IRA_ADDR_RESET;
      wr_kind_q <= 1'b0;
    end
    else if (addr_wr_i)
    begin
      addr_q <= addr_wdata_i;
      wr_kind_q <= data_written_q || data_wr_i;
    end
  end

  // Set wins: an address write in the service cycle stays pending
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      pending_q <= 1'b0;
    end
    else if (addr_wr_i)
    begin
      pending_q <= 1'b1;
    end
    else if (service)
    begin
      pending_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      done_q <= 1'b0;
    end
    else if (service && done_irq_en_i)
    begin
      done_q <= 1'b1;
    end
    else if (done_clr_i)
    begin
      done_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transfer service
  // ----------------------------------------------------------------
  // Host write to the data port wins over a read completion
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      data_q <= IRA_PORT_RESET;
    end
    else if (data_wr_i)
    begin
      data_q <= data_wdata_i;
    end
    else if (service && !wr_kind_q)
    begin
      data_q <= rd_word(addr_q);
    end
  end

  // Addresses past the store are dropped on write and read as zero
  always_ff @(posedge mclk_i)
  begin
    if (service && wr_kind_q && in_range(addr_q))
    begin
      mem_q[addr_q[4:0]] <= data_q;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      written_q <= '0;
    end
    else if (service && wr_kind_q && in_range(addr_q))
    begin
      written_q[addr_q[4:0]] <= 1'b1;
    end
  end

  assign indirect_data_port_o = data_q;
  assign indirect_addr_port_o = addr_q;
  assign indirect_xfer_pending_o = pending_q;
  assign transfer_done_irq_o = done_q;

  // ----------------------------------------------------------------
  // Threshold decisions
  // ----------------------------------------------------------------
  // Process form so a store write re-evaluates the gate, not only a power change
  logic power_ok;
  always_comb
  begin
    power_ok = !exceeds(rd_word(IRA_DTMF_MIN_TOTAL_POWER), total_power_i);
  end

  genvar gi;
  generate
    for (gi = 0; gi < IRA_LOW_TONES; gi++)
    begin : g_low
      always_ff @(posedge mclk_i)
      begin
        if (reset_i)
        begin
          low_tone_detect_o[gi] <= 1'b0;
        end
        else
        begin
          low_tone_detect_o[gi] <= power_ok &&
            exceeds(low_tone_ratio_i[gi], rd_word(IRA_ADDR_W'(gi)));
        end
      end
    end
    for (gi = 0; gi < IRA_HIGH_TONES; gi++)
    begin : g_high
      always_ff @(posedge mclk_i)
      begin
        if (reset_i)
        begin
          high_tone_detect_o[gi] <= 1'b0;
        end
        else
        begin
          high_tone_detect_o[gi] <= power_ok &&
            exceeds(high_tone_ratio_i[gi], rd_word(IRA_DTMF_HIGH_GROUP_PASS_RATIO));
        end
      end
    end
  endgenerate

  // Twist passes while the ratio stays at or under its limit
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      fwd_twist_ok_o <= 1'b0;
      rev_twist_ok_o <= 1'b0;
      low_dom_ok_o <= 1'b0;
      high_dom_ok_o <= 1'b0;
      low_harm_ok_o <= 1'b0;
      high_harm_ok_o <= 1'b0;
      power_valid_o <= 1'b0;
    end
    else
    begin
      fwd_twist_ok_o <= power_ok &&
        !exceeds(fwd_twist_ratio_i, rd_word(IRA_DTMF_FORWARD_TWIST_LIMIT));
      rev_twist_ok_o <= power_ok &&
        !exceeds(rev_twist_ratio_i, rd_word(IRA_DTMF_REVERSE_TWIST_LIMIT));
      low_dom_ok_o <= power_ok &&
        exceeds(low_dom_ratio_i, rd_word(IRA_DTMF_LOW_GROUP_DOMINANCE));
      high_dom_ok_o <= power_ok &&
        exceeds(high_dom_ratio_i, rd_word(IRA_DTMF_HIGH_GROUP_DOMINANCE));
      low_harm_ok_o <= power_ok &&
        exceeds(low_harm_ratio_i, rd_word(IRA_DTMF_LOW_GROUP_HARMONIC_LIMIT));
      high_harm_ok_o <= power_ok &&
        exceeds(high_harm_ratio_i, rd_word(IRA_DTMF_HIGH_GROUP_HARMONIC_LIMIT));
      power_valid_o <= power_ok;
    end
  end

  // One gain step: attenuate while input sits above the hot limit
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      agc_step_down_o <= 1'b0;
    end
    else
    begin
      agc_step_down_o <= exceeds(input_level_i, rd_word(IRA_DTMF_AGC_HOT_LIMIT));
    end
  end

  // ----------------------------------------------------------------
  // Tone generator coefficients
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      tone_gen_one_freq_coef_o <= IRA_PORT_RESET;
      tone_gen_one_amplitude_o <= IRA_PORT_RESET;
      tone_gen_one_initial_phase_o <= IRA_PORT_RESET;
      tone_gen_two_freq_coef_o <= IRA_PORT_RESET;
      tone_gen_two_amplitude_o <= IRA_PORT_RESET;
      tone_gen_two_initial_phase_o <= IRA_PORT_RESET;
    end
    else
    begin
      tone_gen_one_freq_coef_o <= rd_word(IRA_TONE_GEN_ONE_FREQ_COEF);
      tone_gen_one_amplitude_o <= rd_word(IRA_TONE_GEN_ONE_AMPLITUDE);
      tone_gen_one_initial_phase_o <= rd_word(IRA_TONE_GEN_ONE_INITIAL_PHASE);
      tone_gen_two_freq_coef_o <= rd_word(IRA_TONE_GEN_TWO_FREQ_COEF);
      tone_gen_two_amplitude_o <= rd_word(IRA_TONE_GEN_TWO_AMPLITUDE);
      tone_gen_two_initial_phase_o <= rd_word(IRA_TONE_GEN_TWO_INITIAL_PHASE);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_write_req;
    data_wr_i && !addr_wr_i ##1 (addr_wr_i && !data_wr_i);
  endsequence

  sequence s_read_req;
    addr_wr_i && !data_wr_i && !data_written_q;
  endsequence

  chk_write_kind: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_write_req |=> wr_kind_q && pending_q)
    else $error("data then address did not make a write request");

  chk_read_kind: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_read_req |=> !wr_kind_q && pending_q)
    else $error("lone address write did not make a read request");

  chk_read_copy: assert property (@(posedge mclk_i) disable iff (reset_i)
    (service && !wr_kind_q && !data_wr_i) |=> data_q == rd_word($past(addr_q)))
    else $error("read did not copy the stored word to the data port");

  chk_write_store: assert property (@(posedge mclk_i) disable iff (reset_i)
    (service && wr_kind_q && in_range(addr_q)) |=> rd_word($past(addr_q)) == $past(data_q))
    else $error("write did not store the data word");

  chk_tick_only: assert property (@(posedge mclk_i) disable iff (reset_i)
    $fell(pending_q) |-> $past(tick))
    else $error("pending flag dropped without an update tick");

  chk_pending_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
    (pending_q && !tick) |=> pending_q)
    else $error("pending flag dropped before service");

  chk_service_pair: assert property (@(posedge mclk_i) disable iff (reset_i)
    (service && !addr_wr_i && done_irq_en_i) |=> !pending_q && done_q)
    else $error("service did not clear pending and set done together");

  chk_done_cause: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(done_q) |-> $past(service) && $past(done_irq_en_i))
    else $error("done flag rose without a serviced transfer");

  chk_power_gate: assert property (@(posedge mclk_i) disable iff (reset_i)
    !power_valid_o |-> (low_tone_detect_o == '0) && (high_tone_detect_o == '0))
    else $error("tone detect raised below minimum power");

endmodule

`default_nettype wire

// ### verification/ira_host_model.sv
// Host model: writes the direct data and address ports of the indirect store.
// Assumes the bench calls xfer; strobes change only at the falling edge.
`timescale 1ns/1ps
`default_nettype none

module ira_host_model
  import ira_pkg::*;
#(
  parameter int TICK_CYCLES = 16
)
(
  // Clock
  input wire logic mclk_i,
  // Host strobes
  output logic data_wr_o,
  output ira_pkg::ira_word_t data_wdata_o,
  output logic addr_wr_o,
  output ira_pkg::ira_addr_t addr_wdata_o,
  // Status
  input wire logic pending_i
);
  import ira_pkg::*;

  int cyc = 0;
  int done_cyc = 0;

  initial
  begin
    data_wr_o = 1'b0;
    data_wdata_o = 16'h0000;
    addr_wr_o = 1'b0;
    addr_wdata_o = 8'h00;
  end

  always @(posedge mclk_i)
    cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // One transfer: data then address is a write, address alone a read
  // ----------------------------------------------------------------
  task automatic xfer(input bit wr, input ira_word_t d, input ira_addr_t a, output bit ok);
    bit hi;
    @(negedge mclk_i);
    if (wr)
    begin
      data_wr_o = 1'b1;
      data_wdata_o = d;
      @(negedge mclk_i);
      data_wr_o = 1'b0;
      // Released lines show garbage, not the last value
      data_wdata_o = ~d;
    end
    addr_wr_o = 1'b1;
    addr_wdata_o = a;
    @(negedge mclk_i);
    addr_wr_o = 1'b0;
    addr_wdata_o = ~a;
    hi = (pending_i === 1'b1);
    for (int n = 0; n < TICK_CYCLES + 4; n++)
    begin
      if (pending_i === 1'b0)
        break;
      @(negedge mclk_i);
    end
    ok = hi && (pending_i === 1'b0);
    done_cyc = cyc;
  endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the indirect register store.
// Assumes ira_regs and the host model; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import ira_pkg::*;

  localparam int TICK = 16;
  logic mclk_i;
  logic reset_i;
  logic data_wr;
  logic addr_wr;
  logic irq_en;
  logic done_clr;
  ira_word_t wdata;
  ira_addr_t waddr;
  ira_word_t dport;
  ira_addr_t aport;
  logic pend;
  logic done;
  logic [3:0][15:0] low_r;
  logic [3:0][15:0] high_r;
  ira_word_t ms [8];
  logic [3:0] low_det;
  logic [3:0] high_det;
  wire logic [7:0] oks;
  wire ira_word_t coef [6];
  ira_word_t mem [IRA_DEPTH];
  int err_count = 0;
  int compares = 0;
  int seed = 32'h3ae9;
  int first;
  bit ok;
  logic [15:0] exp_dec;

  ira_regs #(.TICK_CYCLES(TICK)) i_dut (
    .mclk_i(mclk_i), .reset_i(reset_i),
    .data_wr_i(data_wr), .data_wdata_i(wdata), .indirect_data_port_o(dport),
    .addr_wr_i(addr_wr), .addr_wdata_i(waddr), .indirect_addr_port_o(aport),
    .indirect_xfer_pending_o(pend), .done_irq_en_i(irq_en), .done_clr_i(done_clr),
    .transfer_done_irq_o(done), .low_tone_ratio_i(low_r), .high_tone_ratio_i(high_r),
    .fwd_twist_ratio_i(ms[0]), .rev_twist_ratio_i(ms[1]), .low_dom_ratio_i(ms[2]),
    .high_dom_ratio_i(ms[3]), .low_harm_ratio_i(ms[4]), .high_harm_ratio_i(ms[5]),
    .total_power_i(ms[6]), .input_level_i(ms[7]),
    .low_tone_detect_o(low_det), .high_tone_detect_o(high_det),
    .fwd_twist_ok_o(oks[0]), .rev_twist_ok_o(oks[1]), .low_dom_ok_o(oks[2]),
    .high_dom_ok_o(oks[3]), .low_harm_ok_o(oks[4]), .high_harm_ok_o(oks[5]),
    .power_valid_o(oks[6]), .agc_step_down_o(oks[7]),
    .tone_gen_one_freq_coef_o(coef[0]), .tone_gen_one_amplitude_o(coef[1]),
    .tone_gen_one_initial_phase_o(coef[2]), .tone_gen_two_freq_coef_o(coef[3]),
    .tone_gen_two_amplitude_o(coef[4]), .tone_gen_two_initial_phase_o(coef[5])
  );

  ira_host_model #(.TICK_CYCLES(TICK)) i_host (
    .mclk_i(mclk_i), .data_wr_o(data_wr), .data_wdata_o(wdata),
    .addr_wr_o(addr_wr), .addr_wdata_o(waddr), .pending_i(pend)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("counts: compares=%0d mismatches=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Decisions from the inputs held over the last edge
  function automatic logic [15:0] want();
    logic pv;
    logic [15:0] r;
    pv = $signed(ms[6]) >= $signed(mem[11]);
    for (int i = 0; i < 4; i++)
    begin
      r[12 + i] = pv && ($signed(low_r[i]) > $signed(mem[i]));
      r[8 + i] = pv && ($signed(high_r[i]) > $signed(mem[4]));
    end
    r[7] = pv && ($signed(ms[0]) <= $signed(mem[5]));
    r[6] = pv && ($signed(ms[1]) <= $signed(mem[6]));
    r[5] = pv && ($signed(ms[2]) > $signed(mem[7]));
    r[4] = pv && ($signed(ms[3]) > $signed(mem[8]));
    r[3] = pv && ($signed(ms[4]) > $signed(mem[9]));
    r[2] = pv && ($signed(ms[5]) > $signed(mem[10]));
    r[1] = pv;
    r[0] = $signed(ms[7]) > $signed(mem[12]);
    return r;
  endfunction

  task automatic done_check(input logic exp);
    chk(done, exp);
    chk(pend, 1'b0);
    chk((i_host.done_cyc - first) % TICK, 0);
    done_clr = 1'b1;
    @(negedge mclk_i);
    done_clr = 1'b0;
    chk(done, 1'b0);
  endtask

  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  initial
  begin
    #80000;
    err_count++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset_i = 1'b1;
    irq_en = 1'b1;
    done_clr = 1'b0;
    low_r = '0;
    high_r = '0;
    for (int i = 0; i < 8; i++)
      ms[i] = 16'h0000;
    repeat (16) @(negedge mclk_i);
    reset_i = 1'b0;
    chk(pend, 1'b0);
    chk(dport, 16'h0000);
    first = -1;
    for (int a = 0; a < IRA_DEPTH; a++)
    begin
      mem[a] = 16'($random(seed));
      if (a == 19)
        mem[a] = mem[a] & 16'h1f80;
      i_host.xfer(1'b1, mem[a], 8'(a), ok);
      if (first < 0)
        first = i_host.done_cyc;
      chk(ok, 1'b1);
      chk(aport, 16'(a));
      done_check(1'b1);
    end
    for (int k = 0; k < 6; k++)
      chk(coef[k], mem[13 + k]);
    $display("writes done");
    for (int a = IRA_DEPTH; a >= 0; a--)
    begin
      irq_en = a[0];
      i_host.xfer(1'b0, 16'h0000, 8'(a), ok);
      chk(ok, 1'b1);
      chk(dport, (a < IRA_DEPTH) ? mem[a] : 16'h0000);
      done_check(a[0]);
    end
    irq_en = 1'b1;
    $display("reads done");
    for (int n = 0; n < 80; n++)
    begin
      low_r = {$random(seed), $random(seed)};
      high_r = {$random(seed), $random(seed)};
      for (int i = 0; i < 8; i++)
        ms[i] = 16'($random(seed));
      if (n % 4 == 0)
      begin
        low_r[0] = mem[0];
        high_r[1] = mem[4];
        ms[0] = mem[5];
        ms[6] = mem[11];
        ms[7] = mem[12];
        ms[2] = mem[7];
        ms[5] = mem[10];
      end
      @(negedge mclk_i);
      exp_dec = want();
      chk({low_det, high_det}, exp_dec[15:8]);
      chk({oks[0], oks[1]}, exp_dec[7:6]);
      chk({oks[2], oks[3], oks[4], oks[5]}, exp_dec[5:2]);
      chk({oks[6], oks[7]}, exp_dec[1:0]);
    end
    $display("decisions done");
    // Mid-run reset: outputs clear and the tick restarts
    reset_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    reset_i = 1'b0;
    chk({pend, done, aport}, 16'h0000);
    chk(dport, 16'h0000);
    chk(coef[0], 16'h0000);
    mem[7] = 16'($random(seed));
    i_host.xfer(1'b1, mem[7], 8'h07, ok);
    first = i_host.done_cyc;
    chk(ok, 1'b1);
    done_check(1'b1);
    i_host.xfer(1'b0, 16'h0000, 8'h07, ok);
    chk({ok, aport}, {1'b1, 8'h07});
    chk(dport, mem[7]);
    done_check(1'b1);
    $display("reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
